// ---- verilog/aocr_pkg.sv ----
`default_nettype none
package aocr_pkg;

  // Register indexes; the bus byte address is four times the index.
  localparam logic [7:0] AOCR_IDX_IN2    = 8'hd8;
  localparam logic [7:0] AOCR_IDX_IN3    = 8'hda;
  localparam logic [7:0] AOCR_IDX_IN4    = 8'hdc;
  localparam logic [7:0] AOCR_IDX_IN5    = 8'hde;
  localparam logic [7:0] AOCR_IDX_IN6    = 8'he0;
  localparam logic [7:0] AOCR_IDX_STATUS = 8'he4;

  localparam int unsigned AOCR_NUM_CH = 5;
  localparam logic [AOCR_NUM_CH-1:0][7:0] AOCR_IDX_TABLE =
    {AOCR_IDX_IN6, AOCR_IDX_IN5, AOCR_IDX_IN4, AOCR_IDX_IN3, AOCR_IDX_IN2};

  // Bus geometry.
  localparam int unsigned AOCR_ADDR_W    = 12;
  localparam int unsigned AOCR_WORD_LSB  = 2;
  localparam int unsigned AOCR_WORD_W    = AOCR_ADDR_W - AOCR_WORD_LSB;
  localparam int unsigned AOCR_DATA_W    = 32;
  localparam int unsigned AOCR_STRB_W    = 4;
  localparam int unsigned AOCR_LANE0     = 0;
  localparam int unsigned AOCR_LANE1     = 1;
  localparam logic [1:0]  AOCR_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  AOCR_RESP_SLVERR = 2'h2;

  // Trim word layout: bits 15..10 reserved, 9..0 signed trim.
  localparam int unsigned AOCR_TRIM_W     = 10;
  localparam int unsigned AOCR_TRIM_MSB   = 9;
  localparam int unsigned AOCR_LANE0_MSB  = 7;
  localparam int unsigned AOCR_LANE1_LSB  = 8;
  localparam int unsigned AOCR_RESERVED_LSB = 10;
  localparam logic [AOCR_TRIM_W-1:0] AOCR_TRIM_RESET = 10'h000;

  // Status register layout.
  localparam int unsigned AOCR_ST_CLAMP_BIT = 16;
  localparam int unsigned AOCR_ST_CHAN_LSB  = 17;
  localparam int unsigned AOCR_ST_CHAN_MSB  = 19;

  // Conversion result scale: one LSB is 5 V / 2^16.
  localparam int unsigned AOCR_RES_W    = 16;
  localparam int unsigned AOCR_SUM_W    = 18;
  localparam int unsigned AOCR_CHAN_W   = 3;
  localparam logic [AOCR_RES_W-1:0]  AOCR_RES_MAX   = 16'hffff;
  localparam logic [AOCR_RES_W-1:0]  AOCR_RES_MIN   = 16'h0000;
  localparam logic [AOCR_RES_W-1:0]  AOCR_RES_ONE   = 16'h0001;
  localparam logic [AOCR_CHAN_W-1:0] AOCR_CHAN_FIRST = 3'h2;
  localparam logic [AOCR_CHAN_W-1:0] AOCR_CHAN_LAST  = 3'h6;
  localparam logic [AOCR_TRIM_W-1:0] AOCR_TRIM_ONE   = 10'h001;
  localparam int AOCR_STEP_MIN = -512;
  localparam int AOCR_STEP_MAX = 511;

endpackage
`default_nettype wire

// ---- verilog/aocr_trim_adder.sv ----
`timescale 1ns/10ps
`default_nettype none
module aocr_trim_adder
  import aocr_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  // Raw result
  input  wire logic                   i_valid,
  input  wire logic                   i_apply,
  input  wire logic [AOCR_RES_W-1:0]  i_result,
  input  wire logic [AOCR_TRIM_W-1:0] i_trim,
  // Corrected result
  output logic                        o_valid,
  output logic      [AOCR_RES_W-1:0]  o_result,
  output logic                        o_clamped
);

  logic signed [AOCR_SUM_W-1:0] sum;
  logic                         over;
  logic                         under;
  logic                         valid_d;
  logic                         valid_q;
  logic [AOCR_RES_W-1:0]        result_d;
  logic [AOCR_RES_W-1:0]        result_q;
  logic                         clamped_d;
  logic                         clamped_q;

  always_comb
  begin
    sum = $signed({2'b00, i_result})
        + $signed({{(AOCR_SUM_W-AOCR_TRIM_W){i_trim[AOCR_TRIM_MSB]}}, i_trim}); // RULE_02
    over  = sum > $signed({2'b00, AOCR_RES_MAX});
    under = sum < $signed({2'b00, AOCR_RES_MIN});
    valid_d   = i_valid;
    result_d  = result_q;
    clamped_d = clamped_q;
    if (i_valid)
    begin
      if (!i_apply)
      begin
        result_d  = i_result;
        clamped_d = 1'b0;
      end
      else if (over)
      begin
        result_d  = AOCR_RES_MAX; // RULE_06
        clamped_d = 1'b1;
      end
      else if (under)
      begin
        result_d  = AOCR_RES_MIN; // RULE_06
        clamped_d = 1'b1;
      end
      else
      begin
        result_d  = sum[AOCR_RES_W-1:0]; // RULE_03
        clamped_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      valid_q   <= 1'b0;
      result_q  <= AOCR_RES_MIN;
      clamped_q <= 1'b0;
    end
    else
    begin
      valid_q   <= valid_d;
      result_q  <= result_d;
      clamped_q <= clamped_d;
    end
  end

  assign o_valid   = valid_q;
  assign o_result  = result_q;
  assign o_clamped = clamped_q;

  chk_trim_added: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_02
    i_valid && i_apply && !over && !under |=> o_valid && !o_clamped
      && o_result == $past(i_result) + {{(AOCR_RES_W-AOCR_TRIM_W){$past(i_trim[AOCR_TRIM_MSB])}},
                                        $past(i_trim)})
    else $error("corrected result is not raw result plus trim");

  chk_unit_step: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_03
    i_valid && i_apply && i_trim == AOCR_TRIM_ONE && i_result != AOCR_RES_MAX
      |=> o_result == $past(i_result) + AOCR_RES_ONE)
    else $error("one trim unit is not one result LSB");

  chk_step_range: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_04
    i_valid && i_apply |=>
      ($signed({2'b00, o_result}) - $signed({2'b00, $past(i_result)})) >= AOCR_STEP_MIN
      && ($signed({2'b00, o_result}) - $signed({2'b00, $past(i_result)})) <= AOCR_STEP_MAX)
    else $error("correction outside the trim span");

  chk_clamp_high: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_06
    i_valid && i_apply && over |=> o_result == AOCR_RES_MAX && o_clamped)
    else $error("overflow did not clamp to top of range");

  chk_clamp_low: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_06
    i_valid && i_apply && under |=> o_result == AOCR_RES_MIN && o_clamped)
    else $error("underflow did not clamp to zero");

endmodule
`default_nettype wire

// ---- verilog/aocr_top.sv ----
// Notes on behaviour
// RULE_01: Bits 15..10 read zero, writes ignored.
// RULE_02: Bits 9..0 signed trim added to result.
// RULE_03: One trim unit equals one result LSB.
// RULE_04: Correction spans minus 512 to plus 511.
// RULE_05: Five independent trims, indexes 0xd8 to 0xe0.
// RULE_06: Out-of-range corrected results clamp, never wrap.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module aocr_top
  import aocr_pkg::*;
(
  // Clock and reset
  input  wire logic                   I_CORE_CLK,
  input  wire logic                   I_RESET_N,
  // AXI4-Lite write address and data
  input  wire logic [AOCR_ADDR_W-1:0] I_AXI_AWADDR,
  input  wire logic                   I_AXI_AWVALID,
  output logic                        O_AXI_AWREADY,
  input  wire logic [AOCR_DATA_W-1:0] I_AXI_WDATA,
  input  wire logic [AOCR_STRB_W-1:0] I_AXI_WSTRB,
  input  wire logic                   I_AXI_WVALID,
  output logic                        O_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]                  O_AXI_BRESP,
  output logic                        O_AXI_BVALID,
  input  wire logic                   I_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [AOCR_ADDR_W-1:0] I_AXI_ARADDR,
  input  wire logic                   I_AXI_ARVALID,
  output logic                        O_AXI_ARREADY,
  output logic [AOCR_DATA_W-1:0]      O_AXI_RDATA,
  output logic [1:0]                  O_AXI_RRESP,
  output logic                        O_AXI_RVALID,
  input  wire logic                   I_AXI_RREADY,
  // Raw conversion results
  input  wire logic                   I_CONV_VALID,
  input  wire logic [AOCR_CHAN_W-1:0] I_CONV_CHAN,
  input  wire logic [AOCR_RES_W-1:0]  I_CONV_RESULT,
  // Corrected conversion results
  output logic                        O_CORR_VALID,
  output logic [AOCR_CHAN_W-1:0]      O_CORR_CHAN,
  output logic [AOCR_RES_W-1:0]       O_CORR_RESULT,
  output logic                        O_CORR_CLAMPED
);

  logic                   aw_take;
  logic                   w_take;
  logic                   do_write;
  logic                   ar_take;
  logic                   aw_hold_d;
  logic                   aw_hold_q;
  logic [AOCR_WORD_W-1:0] aw_word_d;
  logic [AOCR_WORD_W-1:0] aw_word_q;
  logic                   w_hold_d;
  logic                   w_hold_q;
  logic [AOCR_DATA_W-1:0] w_data_d;
  logic [AOCR_DATA_W-1:0] w_data_q;
  logic [AOCR_STRB_W-1:0] w_strb_d;
  logic [AOCR_STRB_W-1:0] w_strb_q;
  logic                   awready_d;
  logic                   awready_q;
  logic                   wready_d;
  logic                   wready_q;
  logic                   bvalid_d;
  logic                   bvalid_q;
  logic [1:0]             bresp_d;
  logic [1:0]             bresp_q;
  logic                   arready_d;
  logic                   arready_q;
  logic                   rvalid_d;
  logic                   rvalid_q;
  logic [1:0]             rresp_d;
  logic [1:0]             rresp_q;
  logic [AOCR_DATA_W-1:0] rdata_d;
  logic [AOCR_DATA_W-1:0] rdata_q;
  logic [AOCR_WORD_W-1:0] ar_word;
  logic [AOCR_NUM_CH-1:0] wr_hit;
  logic [AOCR_NUM_CH-1:0] rd_hit;
  logic [AOCR_TRIM_W-1:0] trim_d [AOCR_NUM_CH];
  logic [AOCR_TRIM_W-1:0] trim_q [AOCR_NUM_CH];
  logic [AOCR_CHAN_W-1:0] chan_d;
  logic [AOCR_CHAN_W-1:0] chan_q;
  logic                   apply;
  logic [AOCR_TRIM_W-1:0] sel_trim;
  logic [AOCR_CHAN_W-1:0] sel_idx;

  // The write index sits outside the handshake process so its decode forms no loop.
  assign aw_take   = I_AXI_AWVALID && awready_q;
  assign aw_word_d = aw_take ? I_AXI_AWADDR[AOCR_ADDR_W-1:AOCR_WORD_LSB] : aw_word_q;

  // Address and data may arrive in either order; each is parked until both are here.
  always_comb
  begin
    w_take    = I_AXI_WVALID && wready_q;
    aw_hold_d = aw_hold_q || aw_take;
    w_hold_d  = w_hold_q || w_take;
    w_data_d  = w_take ? I_AXI_WDATA : w_data_q;
    w_strb_d  = w_take ? I_AXI_WSTRB : w_strb_q;
    bvalid_d  = bvalid_q && !I_AXI_BREADY;
    bresp_d   = bresp_q;
    do_write  = aw_hold_d && w_hold_d && !bvalid_q;
    if (do_write)
    begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (|wr_hit) ? AOCR_RESP_OKAY : AOCR_RESP_SLVERR;
    end
    awready_d = !aw_hold_d && !bvalid_d;
    wready_d  = !w_hold_d && !bvalid_d;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      aw_hold_q <= 1'b0;
      aw_word_q <= '0;
      w_hold_q  <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= AOCR_RESP_OKAY;
    end
    else
    begin
      aw_hold_q <= aw_hold_d;
      aw_word_q <= aw_word_d;
      w_hold_q  <= w_hold_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // One trim register per channel, each written only through its own index.
  for (genvar i = 0; i < AOCR_NUM_CH; i++)
  begin : g_trim
    assign wr_hit[i] = aw_word_d == {2'b00, AOCR_IDX_TABLE[i]}; // RULE_05
    assign rd_hit[i] = ar_word == {2'b00, AOCR_IDX_TABLE[i]}; // RULE_05

    always_comb
    begin
      trim_d[i] = trim_q[i];
      if (do_write && wr_hit[i])
      begin
        if (w_strb_d[AOCR_LANE0])
        begin
          trim_d[i][AOCR_LANE0_MSB:0] = w_data_d[AOCR_LANE0_MSB:0];
        end
        if (w_strb_d[AOCR_LANE1])
        begin
          trim_d[i][AOCR_TRIM_MSB:AOCR_LANE1_LSB] = w_data_d[AOCR_TRIM_MSB:AOCR_LANE1_LSB]; // RULE_01
        end
      end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
    begin
      if (!I_RESET_N)
      begin
        trim_q[i] <= AOCR_TRIM_RESET;
      end
      else
      begin
        trim_q[i] <= trim_d[i];
      end
    end
  end

  assign ar_word = I_AXI_ARADDR[AOCR_ADDR_W-1:AOCR_WORD_LSB];

  // Reads answer one cycle after the address is taken.
  always_comb
  begin
    ar_take   = I_AXI_ARVALID && arready_q;
    rvalid_d  = rvalid_q && !I_AXI_RREADY;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (ar_take)
    begin
      rvalid_d = 1'b1;
      rdata_d  = '0; // RULE_01
      rresp_d  = AOCR_RESP_SLVERR;
      for (int k = 0; k < AOCR_NUM_CH; k++)
      begin
        if (rd_hit[k])
        begin
          rdata_d[AOCR_TRIM_MSB:0] = trim_q[k];
          rresp_d                  = AOCR_RESP_OKAY;
        end
      end
      if (ar_word == {2'b00, AOCR_IDX_STATUS})
      begin
        rdata_d[AOCR_RES_W-1:0]                       = O_CORR_RESULT;
        rdata_d[AOCR_ST_CLAMP_BIT]                    = O_CORR_CLAMPED;
        rdata_d[AOCR_ST_CHAN_MSB:AOCR_ST_CHAN_LSB]    = O_CORR_CHAN;
        rresp_d                                       = AOCR_RESP_OKAY;
      end
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= AOCR_RESP_OKAY;
    end
    else
    begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // Channels outside 2..6 pass through untouched; their trims live elsewhere.
  always_comb
  begin
    apply    = I_CONV_CHAN >= AOCR_CHAN_FIRST && I_CONV_CHAN <= AOCR_CHAN_LAST;
    sel_idx  = I_CONV_CHAN - AOCR_CHAN_FIRST;
    sel_trim = AOCR_TRIM_RESET;
    for (int k = 0; k < AOCR_NUM_CH; k++)
    begin
      if (apply && sel_idx == k[AOCR_CHAN_W-1:0])
      begin
        sel_trim = trim_q[k]; // RULE_02
      end
    end
    chan_d = I_CONV_VALID ? I_CONV_CHAN : chan_q;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      chan_q <= '0;
    end
    else
    begin
      chan_q <= chan_d;
    end
  end

  aocr_trim_adder u_adder (
    .i_clk     (I_CORE_CLK),
    .i_rst_n   (I_RESET_N),
    .i_valid   (I_CONV_VALID),
    .i_apply   (apply),
    .i_result  (I_CONV_RESULT),
    .i_trim    (sel_trim),
    .o_valid   (O_CORR_VALID),
    .o_result  (O_CORR_RESULT),
    .o_clamped (O_CORR_CLAMPED)
  );

  assign O_CORR_CHAN   = chan_q;
  assign O_AXI_AWREADY = awready_q;
  assign O_AXI_WREADY  = wready_q;
  assign O_AXI_BVALID  = bvalid_q;
  assign O_AXI_BRESP   = bresp_q;
  assign O_AXI_ARREADY = arready_q;
  assign O_AXI_RVALID  = rvalid_q;
  assign O_AXI_RDATA   = rdata_q;
  assign O_AXI_RRESP   = rresp_q;

  chk_reserved_read_zero: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N) // RULE_01
    ar_take && (|rd_hit) |=> O_AXI_RVALID && O_AXI_RRESP == AOCR_RESP_OKAY
      && O_AXI_RDATA[AOCR_DATA_W-1:AOCR_RESERVED_LSB] == '0)
    else $error("trim read shows nonzero reserved bits");

  chk_trim_store: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N) // RULE_05
    do_write && wr_hit[0] && w_strb_d[AOCR_LANE0] && w_strb_d[AOCR_LANE1]
      |=> trim_q[0] == $past(w_data_d[AOCR_TRIM_MSB:0]) && trim_q[1] == $past(trim_q[1]))
    else $error("trim write missed its register or touched another");

  chk_write_resp: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    do_write |=> O_AXI_BVALID && !O_AXI_AWREADY && !O_AXI_WREADY)
    else $error("write response not raised one cycle after the write");

  chk_unmapped_err: assert property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
    ar_take && !(|rd_hit) && ar_word != {2'b00, AOCR_IDX_STATUS}
      |=> O_AXI_RRESP == AOCR_RESP_SLVERR && O_AXI_RDATA == '0)
    else $error("unmapped read not answered with error and zero");

endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench
  import aocr_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic [11:0] awaddr;
  logic [11:0] araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awvalid;
  logic        wvalid;
  logic        bready;
  logic        arvalid;
  logic        rready;
  logic        awready;
  logic        wready;
  logic        arready;
  logic        bvalid;
  logic        rvalid;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [31:0] rdata;
  logic        cv_in;
  logic [2:0]  cc_in;
  logic [15:0] cr_in;
  logic        cv;
  logic [2:0]  cc;
  logic [15:0] cr;
  logic        ccl;
  int          err_count = 0;
  int          cmp_count = 0;
  logic [9:0]  trims [5] = '{10'h1ff, 10'h200, 10'h3ff, 10'h001, 10'h155};

  initial clk = 1'b0;
  always #10 clk = ~clk;

  aocr_top u_dut (
    .I_CORE_CLK(clk), .I_RESET_N(rst_n),
    .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready),
    .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb), .I_AXI_WVALID(wvalid),
    .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid),
    .I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid),
    .O_AXI_ARREADY(arready), .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp),
    .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
    .I_CONV_VALID(cv_in), .I_CONV_CHAN(cc_in), .I_CONV_RESULT(cr_in),
    .O_CORR_VALID(cv), .O_CORR_CHAN(cc), .O_CORR_RESULT(cr),
    .O_CORR_CLAMPED(ccl)
  );

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  function automatic logic [11:0] adr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    r = bresp;
    bready <= 1'b0;
    if (n >= 100)
    begin
      check(1'b0, 1'b1, "write timeout");
      end_sim();
    end
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100)
    begin
      check(1'b0, 1'b1, "read timeout");
      end_sim();
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic test_zero();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 5; i++)
    begin
      axr(adr(AOCR_IDX_TABLE[i]), d, r);
      check(d, 32'h0000_0000, "trim after reset");
      check(r, AOCR_RESP_OKAY, "read resp");
    end
    $display("test zero done");
  endtask

  // Software keeps the reserved bits at zero; the lanes above the register carry ones
  // on purpose, and none of them may ever read back.
  task automatic test_regs();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 5; i++)
    begin
      axw(adr(AOCR_IDX_TABLE[i]), 32'hffff_0000 | trims[i], 4'hf, r);
      check(r, AOCR_RESP_OKAY, "write resp");
    end
    for (int i = 0; i < 5; i++)
    begin
      axr(adr(AOCR_IDX_TABLE[i]), d, r);
      check(d, {22'h0, trims[i]}, "trim readback");
    end
    axw(12'h364, 32'h0000_0155, 4'hf, r);
    check(r, AOCR_RESP_SLVERR, "unmapped write");
    axr(12'h364, d, r);
    check(d, 32'h0000_0000, "unmapped data");
    check(r, AOCR_RESP_SLVERR, "unmapped read");
    axw(adr(AOCR_IDX_STATUS), 32'h0000_0001, 4'hf, r);
    check(r, AOCR_RESP_SLVERR, "status write");
    axr(adr(AOCR_IDX_IN2), d, r);
    check(d, {22'h0, trims[0]}, "trim kept");
    $display("test regs done");
  endtask

  task automatic conv(input logic [2:0] ch, input logic [15:0] res);
    int s;
    logic [15:0] e;
    logic        c;
    s = int'(res);
    if (ch >= AOCR_CHAN_FIRST && ch <= AOCR_CHAN_LAST) s = s + int'($signed(trims[ch - 2]));
    c = (s > 65535) || (s < 0);
    e = (s > 65535) ? 16'hffff : (s < 0) ? 16'h0000 : s[15:0];
    @(posedge clk);
    cv_in <= 1'b1;
    cc_in <= ch;
    cr_in <= res;
    @(posedge clk);
    cv_in <= 1'b0;
    #1;
    check(cv, 1'b1, "corr valid");
    check(cc, ch, "corr chan");
    check(cr, e, "corr result");
    check(ccl, c, "clamp flag");
    @(posedge clk);
    #1;
    check(cv, 1'b0, "valid pulse");
  endtask

  // Extreme trims meet results near both ends of the scale.
  task automatic test_conv();
    logic [15:0] res [4] = '{16'h8000, 16'hfffe, 16'hffff, 16'h0001};
    logic [31:0] d;
    logic [1:0]  r;
    conv(3'h2, 16'h8000);
    check(cr, 32'h0000_81ff, "top of span");
    conv(3'h3, 16'h8000);
    check(cr, 32'h0000_7e00, "bottom of span");
    for (int ch = 0; ch < 8; ch++)
      for (int k = 0; k < 4; k++)
        conv(3'(ch), res[k]);
    axr(adr(AOCR_IDX_STATUS), d, r);
    check(d, {12'h0, 3'h7, 1'b0, 16'h0001}, "status");
    $display("test conv done");
  endtask

  task automatic test_lanes();
    logic [31:0] d;
    logic [1:0]  r;
    axw(adr(AOCR_IDX_IN2), 32'h0000_03ff, 4'h3, r);
    axw(adr(AOCR_IDX_IN2), 32'h0000_0000, 4'h1, r);
    axw(adr(AOCR_IDX_IN2), 32'h0000_0000, 4'hc, r);
    axr(adr(AOCR_IDX_IN2), d, r);
    check(d, 32'h0000_0300, "lane writes");
    $display("test lanes done");
  endtask

  initial
  begin
    rst_n = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    cv_in = 1'b0;
    cc_in = '0;
    cr_in = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    test_zero();
    test_regs();
    test_conv();
    test_lanes();
    do_reset();
    test_zero();
    end_sim();
  end

  // The whole sequence needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
